/* include/atpp_pkg.sv */
// Shared constants and types of the angular timer period, phase and enable registers
`default_nettype none

package atpp_pkg;

   // ==========================================================================
   // Bus shape
   // ==========================================================================
   localparam int unsigned AXI_ADDR_W = 8;
   localparam int unsigned AXI_DATA_W = 32;
   localparam int unsigned AXI_STRB_W = 4;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================================
   // Register byte offsets
   // ==========================================================================
   localparam logic [7:0] OFF_PERIOD_LOW = 8'h00;
   localparam logic [7:0] OFF_PERIOD_HIGH = 8'h04;
   localparam logic [7:0] OFF_PHASE_HIGH = 8'h08;
   localparam logic [7:0] OFF_PHASE_LOW = 8'h0c;
   localparam logic [7:0] OFF_ENABLES = 8'h10;
   localparam logic [7:0] OFF_FLAGS = 8'h14;

   // ==========================================================================
   // Field positions and widths
   // ==========================================================================
   localparam int unsigned EVENT_COUNT = 3;
   localparam int unsigned EV_PHASE_BIT = 2;
   localparam int unsigned EV_MISSED_BIT = 1;
   localparam int unsigned EV_PERIOD_BIT = 0;
   localparam int unsigned OVERFLOW_BIT = 7;
   localparam int unsigned PERIOD_W_DOC = 15;
   localparam int unsigned PHASE_W_DOC = 10;
   localparam int unsigned BYTE_W = 8;

   // ==========================================================================
   // Values after reset
   // ==========================================================================
   localparam logic [2:0] ENABLES_RESET = 3'h0;
   localparam logic [2:0] FLAGS_RESET = 3'h0;
   localparam logic OVERFLOW_RESET = 1'b0;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

   // ==========================================================================
   // Types
   // ==========================================================================
   // Bit order matches the enable and flag register layout
   typedef struct packed {
      logic phase;
      logic missed;
      logic period;
   } atpp_events_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } atpp_wr_req_t;

   typedef enum logic [1:0] {
      WR_IDLE = 2'b01,
      WR_RESP = 2'b10
   } atpp_wr_state_t;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_DATA = 2'b10
   } atpp_rd_state_t;

endpackage : atpp_pkg

`default_nettype wire

/* core/atpp_event_flags.sv */
// Sticky event flags in which a set always wins over a clear
`default_nettype none

module atpp_event_flags
   import atpp_pkg::*;
#(
   parameter int unsigned FLAG_COUNT = EVENT_COUNT
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [FLAG_COUNT-1:0] set_i,
   input wire logic [FLAG_COUNT-1:0] clear_i,
   input wire logic [FLAG_COUNT-1:0] reset_value_i,
   output logic [FLAG_COUNT-1:0] flags_o
);

   // ==========================================================================
   // Parameter check
   // ==========================================================================
   if (FLAG_COUNT < 1 || FLAG_COUNT > BYTE_W) begin : g_bad_count
      $error("atpp_event_flags: FLAG_COUNT must lie between 1 and 8");
   end

   // ==========================================================================
   // One flag per event
   // ==========================================================================
   for (genvar i = 0; i < FLAG_COUNT; i++) begin : g_flag
      logic flag;
      logic next_flag;

      // An event in the clearing cycle is kept
      assign next_flag = set_i[i] | (flag & ~clear_i[i]);

      always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            flag <= 1'b0;
         end else begin
            flag <= next_flag;
         end
      end

      assign flags_o[i] = flag;
   end

   // Reset value input is unused; every flag resets to zero whatever it is tied to
   logic unused_reset_value;
   assign unused_reset_value = |reset_value_i;

endmodule : atpp_event_flags

`default_nettype wire

/* core/atpp_regs.sv */
// Angular timer result, interrupt enable and flag registers behind an AXI4-Lite slave
`default_nettype none


// Overview of operation
// - Period low byte reads the low eight bits of the measured period, read-only.
// - Phase high bits 1..0 read the top two bits of the live phase counter.
// - Phase high bits 7..2 always read as zero.
// - Phase low byte reads the low eight bits of the live phase counter.
// - Enable register holds phase, missed-pulse, period enables at bits 2..0, reset zero.
// - Event flags at bits 2..0 set on their event and stay until software clears.
// - Period high bit 7 shows the counter rolled over during the last measurement.
module atpp_regs
   import atpp_pkg::*;
#(
   parameter int unsigned PERIOD_WIDTH = PERIOD_W_DOC,
   parameter int unsigned PHASE_WIDTH = PHASE_W_DOC
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // AXI4-Lite write address
   input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   // AXI4-Lite write data
   input wire logic [AXI_DATA_W-1:0] s_axi_wdata_i,
   input wire logic [AXI_STRB_W-1:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // AXI4-Lite read address
   input wire logic [AXI_ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   // AXI4-Lite read data
   output logic [AXI_DATA_W-1:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // Counting engines
   input wire logic [PERIOD_WIDTH-1:0] period_value_i,
   input wire logic period_capture_i,
   input wire logic period_rollover_i,
   input wire logic [PHASE_WIDTH-1:0] phase_value_i,
   input wire atpp_events_t events_i,
   // Interrupt request
   output logic irq_o
);

   // ==========================================================================
   // Parameter checks
   // ==========================================================================
   if (PERIOD_WIDTH < 9 || PERIOD_WIDTH > PERIOD_W_DOC) begin : g_bad_period
      $error("atpp_regs: PERIOD_WIDTH must lie between 9 and 15");
   end
   if (PHASE_WIDTH < 9 || PHASE_WIDTH > PHASE_W_DOC) begin : g_bad_phase
      $error("atpp_regs: PHASE_WIDTH must lie between 9 and 10");
   end

   // ==========================================================================
   // Declarations
   // ==========================================================================
   atpp_wr_state_t wr_state;
   atpp_wr_state_t next_wr_state;
   atpp_rd_state_t rd_state;
   atpp_rd_state_t next_rd_state;

   atpp_wr_req_t wr_req;
   logic aw_held;
   logic w_held;
   logic [1:0] bresp;

   logic [AXI_DATA_W-1:0] rdata;
   logic [1:0] rresp;

   logic [2:0] enables;
   logic [2:0] flags;
   logic period_overflow_indicator;
   logic overflow_pending;

   // ==========================================================================
   // Engine values widened to the documented layout
   // ==========================================================================
   logic [PERIOD_W_DOC-1:0] period_ext;
   logic [PHASE_W_DOC-1:0] phase_ext;
   logic [2:0] event_vec;

   assign period_ext = PERIOD_W_DOC'(period_value_i);
   assign phase_ext = PHASE_W_DOC'(phase_value_i);
   assign event_vec = events_i;

   // ==========================================================================
   // Write channel handshakes
   // ==========================================================================
   logic wr_idle;
   logic aw_take;
   logic w_take;
   logic wr_commit;
   logic b_done;

   assign wr_idle = (wr_state == WR_IDLE);
   assign s_axi_awready_o = wr_idle & ~aw_held;
   assign s_axi_wready_o = wr_idle & ~w_held;
   assign aw_take = s_axi_awvalid_i & s_axi_awready_o;
   assign w_take = s_axi_wvalid_i & s_axi_wready_o;
   // Address and data may arrive in either order; commit once both are held
   assign wr_commit = wr_idle & aw_held & w_held;
   assign b_done = s_axi_bvalid_o & s_axi_bready_i;
   assign s_axi_bvalid_o = (wr_state == WR_RESP);
   assign s_axi_bresp_o = bresp;

   // ==========================================================================
   // Write address decode
   // ==========================================================================
   logic wsel_period_low;
   logic wsel_period_high;
   logic wsel_phase_high;
   logic wsel_phase_low;
   logic wsel_enables;
   logic wsel_flags;
   logic wsel_mapped;
   logic wr_lane0;

   assign wsel_period_low = (wr_req.addr[7:2] == OFF_PERIOD_LOW[7:2]);
   assign wsel_period_high = (wr_req.addr[7:2] == OFF_PERIOD_HIGH[7:2]);
   assign wsel_phase_high = (wr_req.addr[7:2] == OFF_PHASE_HIGH[7:2]);
   assign wsel_phase_low = (wr_req.addr[7:2] == OFF_PHASE_LOW[7:2]);
   assign wsel_enables = (wr_req.addr[7:2] == OFF_ENABLES[7:2]);
   assign wsel_flags = (wr_req.addr[7:2] == OFF_FLAGS[7:2]);
   assign wsel_mapped = wsel_period_low | wsel_period_high | wsel_phase_high
                      | wsel_phase_low | wsel_enables | wsel_flags;
   // All fields live in byte lane 0
   assign wr_lane0 = wr_req.strb[0];

   logic wr_enables;
   logic wr_flags;

   assign wr_enables = wr_commit & wsel_enables & wr_lane0;
   assign wr_flags = wr_commit & wsel_flags & wr_lane0;

   // ==========================================================================
   // Write channel state
   // ==========================================================================
   always_comb begin
      next_wr_state = wr_state;
      case (wr_state)
         WR_IDLE: begin
            if (wr_commit) begin
               next_wr_state = WR_RESP;
            end
         end
         WR_RESP: begin
            if (b_done) begin
               next_wr_state = WR_IDLE;
            end
         end
         default: begin
            next_wr_state = WR_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_state <= WR_IDLE;
      end else begin
         wr_state <= next_wr_state;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         wr_req <= '0;
      end else begin
         if (aw_take) begin
            aw_held <= 1'b1;
            wr_req.addr <= s_axi_awaddr_i;
         end else if (wr_commit) begin
            aw_held <= 1'b0;
         end
         if (w_take) begin
            w_held <= 1'b1;
            wr_req.data <= s_axi_wdata_i;
            wr_req.strb <= s_axi_wstrb_i;
         end else if (wr_commit) begin
            w_held <= 1'b0;
         end
      end
   end

   // Writes to read-only registers are accepted and ignored
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bresp <= RESP_OKAY;
      end else if (wr_commit) begin
         bresp <= wsel_mapped ? RESP_OKAY : RESP_SLVERR;
      end
   end

   // ==========================================================================
   // Read channel handshakes and decode
   // ==========================================================================
   logic ar_take;
   logic r_done;
   logic rsel_period_low;
   logic rsel_period_high;
   logic rsel_phase_high;
   logic rsel_phase_low;
   logic rsel_enables;
   logic rsel_flags;
   logic rsel_mapped;

   assign s_axi_arready_o = (rd_state == RD_IDLE);
   assign ar_take = s_axi_arvalid_i & s_axi_arready_o;
   assign r_done = s_axi_rvalid_o & s_axi_rready_i;
   assign s_axi_rvalid_o = (rd_state == RD_DATA);
   assign s_axi_rdata_o = rdata;
   assign s_axi_rresp_o = rresp;

   assign rsel_period_low = (s_axi_araddr_i[7:2] == OFF_PERIOD_LOW[7:2]);
   assign rsel_period_high = (s_axi_araddr_i[7:2] == OFF_PERIOD_HIGH[7:2]);
   assign rsel_phase_high = (s_axi_araddr_i[7:2] == OFF_PHASE_HIGH[7:2]);
   assign rsel_phase_low = (s_axi_araddr_i[7:2] == OFF_PHASE_LOW[7:2]);
   assign rsel_enables = (s_axi_araddr_i[7:2] == OFF_ENABLES[7:2]);
   assign rsel_flags = (s_axi_araddr_i[7:2] == OFF_FLAGS[7:2]);
   assign rsel_mapped = rsel_period_low | rsel_period_high | rsel_phase_high
                      | rsel_phase_low | rsel_enables | rsel_flags;

   // ==========================================================================
   // Read data selection
   // ==========================================================================
   logic [7:0] byte_period_low;
   logic [7:0] byte_period_high;
   logic [7:0] byte_phase_high;
   logic [7:0] byte_phase_low;
   logic [7:0] byte_enables;
   logic [7:0] byte_flags;
   logic [7:0] rd_byte;

   assign byte_period_low = period_ext[7:0];
   assign byte_period_high = {period_overflow_indicator, period_ext[14:8]};
   assign byte_phase_high = {6'h00, phase_ext[9:8]};
   assign byte_phase_low = phase_ext[7:0];
   assign byte_enables = {5'h00, enables};
   assign byte_flags = {5'h00, flags};

   assign rd_byte = ({8{rsel_period_low}} & byte_period_low)
                  | ({8{rsel_period_high}} & byte_period_high)
                  | ({8{rsel_phase_high}} & byte_phase_high)
                  | ({8{rsel_phase_low}} & byte_phase_low)
                  | ({8{rsel_enables}} & byte_enables)
                  | ({8{rsel_flags}} & byte_flags);

   // ==========================================================================
   // Read channel state
   // ==========================================================================
   always_comb begin
      next_rd_state = rd_state;
      case (rd_state)
         RD_IDLE: begin
            if (ar_take) begin
               next_rd_state = RD_DATA;
            end
         end
         RD_DATA: begin
            if (r_done) begin
               next_rd_state = RD_IDLE;
            end
         end
         default: begin
            next_rd_state = RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_state <= RD_IDLE;
      end else begin
         rd_state <= next_rd_state;
      end
   end

   // Values are sampled at the address handshake and held until taken
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata <= RDATA_RESET;
         rresp <= RESP_OKAY;
      end else if (ar_take) begin
         rdata <= {24'h00_0000, rd_byte};
         rresp <= rsel_mapped ? RESP_OKAY : RESP_SLVERR;
      end
   end

   // ==========================================================================
   // Interrupt enables
   // ==========================================================================
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         enables <= ENABLES_RESET;
      end else if (wr_enables) begin
         enables <= wr_req.data[2:0];
      end
   end

   // ==========================================================================
   // Event flags
   // ==========================================================================
   logic [2:0] flag_clear;
   logic [2:0] clear_by_write;
   logic [2:0] clear_by_read;

   // Writing zero clears a flag, writing one leaves it alone
   assign clear_by_write = wr_flags ? ~wr_req.data[2:0] : 3'h0;
   // Reading the flag register returns the flags and then clears them
   assign clear_by_read = (ar_take & rsel_flags) ? 3'h7 : 3'h0;
   assign flag_clear = clear_by_write | clear_by_read;

   atpp_event_flags #(
      .FLAG_COUNT(EVENT_COUNT)
   ) u_flags (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .set_i(event_vec),
      .clear_i(flag_clear),
      .reset_value_i(FLAGS_RESET),
      .flags_o(flags)
   );

   // ==========================================================================
   // Period overflow indicator
   // ==========================================================================
   // A rollover in the capture cycle still belongs to the ending measurement
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         overflow_pending <= OVERFLOW_RESET;
         period_overflow_indicator <= OVERFLOW_RESET;
      end else if (period_capture_i) begin
         period_overflow_indicator <= overflow_pending | period_rollover_i;
         overflow_pending <= 1'b0;
      end else if (period_rollover_i) begin
         overflow_pending <= 1'b1;
      end
   end

   // ==========================================================================
   // Interrupt request
   // ==========================================================================
   assign irq_o = |(flags & enables);

endmodule : atpp_regs

`default_nettype wire

/* verification/atpp_regs_assertions.sv */
// Concurrent checks on the ports of the angular timer register block
`default_nettype none

module atpp_regs_checker
   import atpp_pkg::*;
#(
   parameter int unsigned PERIOD_WIDTH = PERIOD_W_DOC,
   parameter int unsigned PHASE_WIDTH = PHASE_W_DOC
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic [AXI_DATA_W-1:0] s_axi_wdata_i,
   input wire logic [AXI_STRB_W-1:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [AXI_ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic [AXI_DATA_W-1:0] s_axi_rdata_o,
   input wire logic [1:0] s_axi_rresp_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [PERIOD_WIDTH-1:0] period_value_i,
   input wire logic period_capture_i,
   input wire logic period_rollover_i,
   input wire logic [PHASE_WIDTH-1:0] phase_value_i,
   input wire atpp_events_t events_i,
   input wire logic irq_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   wire logic ar_take = s_axi_arvalid_i && s_axi_arready_o;

   a_bresp_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i
      |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
   a_rdata_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i
      |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped");
   a_ar_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
      else $error("read address taken while data pending");
   a_read_latency: assert property (ar_take |=> s_axi_rvalid_o)
      else $error("read data late");
   a_write_latency: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
      s_axi_wready_o |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o) else $error("write response timing");
   a_period_low_read: assert property (ar_take && s_axi_araddr_i == OFF_PERIOD_LOW
      |=> s_axi_rdata_o == {24'h0, $past(period_value_i[7:0])}) else $error("period low wrong");
   a_phase_high_read: assert property (ar_take && s_axi_araddr_i == OFF_PHASE_HIGH
      |=> s_axi_rdata_o == {30'h0, $past(phase_value_i[PHASE_WIDTH-1 -: 2])})
      else $error("phase high wrong");
   a_phase_low_read: assert property (ar_take && s_axi_araddr_i == OFF_PHASE_LOW
      |=> s_axi_rdata_o == {24'h0, $past(phase_value_i[7:0])}) else $error("phase low wrong");
   a_unmapped_read: assert property (ar_take && s_axi_araddr_i == 8'h18
      |=> s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0) else $error("unmapped read");
   a_irq_has_cause: assert property ($rose(irq_o) |-> $past(events_i != 3'h0) ||
      $past(s_axi_wvalid_i && s_axi_wready_o, 2) || $past(s_axi_awvalid_i && s_axi_awready_o, 2))
      else $error("interrupt rose without cause");
endmodule : atpp_regs_checker

bind atpp_regs atpp_regs_checker #(.PERIOD_WIDTH(PERIOD_WIDTH), .PHASE_WIDTH(PHASE_WIDTH)) u_chk (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(s_axi_awaddr_i),
   .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
   .s_axi_wdata_i(s_axi_wdata_i), .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
   .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
   .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
   .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
   .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
   .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
   .s_axi_rready_i(s_axi_rready_i), .period_value_i(period_value_i),
   .period_capture_i(period_capture_i), .period_rollover_i(period_rollover_i),
   .phase_value_i(phase_value_i), .events_i(events_i), .irq_o(irq_o));

`default_nettype wire

/* verification/test_angular_timer_period_phase_ie.sv */
// Self-checking bench of the angular timer result and enable registers
`default_nettype none

module test_angular_timer_period_phase_ie;
   import atpp_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] data;
      logic [1:0] resp;
   } atpp_row_t;

   // ==========================================================================
   // Stimulus and wiring
   // ==========================================================================
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [14:0] per = 15'h5a3c;
   logic [9:0] phs = 10'h2b7;
   logic cap = 1'b0, roll = 1'b0;
   atpp_events_t ev = 3'h0;
   int bad_count = 0;
   int tests_run = 0;
   logic [31:0] d;
   logic [1:0] r;
   atpp_row_t rows [7] = '{
      '{OFF_PERIOD_LOW, 32'h3c, RESP_OKAY}, '{OFF_PERIOD_HIGH, 32'h5a, RESP_OKAY},
      '{OFF_PHASE_HIGH, 32'h02, RESP_OKAY}, '{OFF_PHASE_LOW, 32'hb7, RESP_OKAY},
      '{OFF_ENABLES, 32'h00, RESP_OKAY}, '{OFF_FLAGS, 32'h00, RESP_OKAY},
      '{8'h18, 32'h00, RESP_SLVERR}};

   always #12.5 clk = ~clk;

   atpp_regs u_atpp_regs (
      .ref_clk_i(clk), .rst_n_i(rst_n), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
      .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
      .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .period_value_i(per), .period_capture_i(cap), .period_rollover_i(roll),
      .phase_value_i(phs), .events_i(ev), .irq_o(irq));

   // ==========================================================================
   // Bus and compare tasks
   // ==========================================================================
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // Ready is raised only once the answer is seen, so the hold checks get exercised
   task automatic wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] resp);
      int n;
      logic aw_ok, w_ok, bv, done;
      n = 0;
      done = 1'b0;
      awaddr <= a;
      wdata <= dv;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!done && n < 100) begin
         @(negedge clk);
         aw_ok = awvalid && awready;
         w_ok = wvalid && wready;
         bv = bvalid;
         done = bvalid && bready;
         resp = bresp;
         @(posedge clk);
         if (aw_ok) awvalid <= 1'b0;
         if (w_ok) wvalid <= 1'b0;
         bready <= bv && !done;
         n++;
      end
      check("write finished", 32'h1, {31'h0, done});
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] resp);
      int n;
      logic ar_ok, rv, done;
      n = 0;
      done = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      while (!done && n < 100) begin
         @(negedge clk);
         ar_ok = arvalid && arready;
         rv = rvalid;
         done = rvalid && rready;
         dv = rdata;
         resp = rresp;
         @(posedge clk);
         if (ar_ok) arvalid <= 1'b0;
         rready <= rv && !done;
         n++;
      end
      check("read finished", 32'h1, {31'h0, done});
   endtask : rd

   task automatic pulse(input atpp_events_t e, input logic ro, input logic ca);
      ev <= e;
      roll <= ro;
      cap <= ca;
      @(posedge clk);
      ev <= 3'h0;
      roll <= 1'b0;
      cap <= 1'b0;
      @(posedge clk);
   endtask : pulse

   task automatic irq_is(input logic exp);
      @(negedge clk);
      check("interrupt", {31'h0, exp}, {31'h0, irq});
      @(posedge clk);
   endtask : irq_is

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize

   // ==========================================================================
   // Test sequence
   // ==========================================================================
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      irq_is(1'b0);
      for (int i = 0; i < 7; i++) begin
         rd(rows[i].addr, d, r);
         check("table data", rows[i].data, d);
         check("table resp", {30'h0, rows[i].resp}, {30'h0, r});
      end
      $display("test register table done");
      wr(OFF_ENABLES, 32'hff, r);
      rd(OFF_ENABLES, d, r);
      check("enables loose bits", 32'h07, d);
      wr(OFF_PERIOD_LOW, 32'hff, r);
      check("read-only write resp", {30'h0, RESP_OKAY}, {30'h0, r});
      rd(OFF_PERIOD_LOW, d, r);
      check("period low kept", 32'h3c, d);
      wr(8'h18, 32'h1, r);
      check("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(OFF_ENABLES, d, r);
      check("enables after reset", 32'h00, d);
      $display("test enables done");
      pulse(3'h7, 1'b0, 1'b0);
      irq_is(1'b0);
      rd(OFF_FLAGS, d, r);
      check("flags set", 32'h07, d);
      rd(OFF_FLAGS, d, r);
      check("flags cleared by read", 32'h00, d);
      wr(OFF_ENABLES, 32'h01, r);
      pulse(3'h4, 1'b0, 1'b0);
      irq_is(1'b0);
      pulse(3'h1, 1'b0, 1'b0);
      irq_is(1'b1);
      wr(OFF_ENABLES, 32'h00, r);
      irq_is(1'b0);
      wr(OFF_ENABLES, 32'h01, r);
      irq_is(1'b1);
      wr(OFF_FLAGS, 32'h00, r);
      irq_is(1'b0);
      $display("test flags and interrupt done");
      pulse(3'h0, 1'b1, 1'b0);
      pulse(3'h0, 1'b0, 1'b1);
      rd(OFF_PERIOD_HIGH, d, r);
      check("overflow set", 32'hda, d);
      pulse(3'h0, 1'b0, 1'b1);
      rd(OFF_PERIOD_HIGH, d, r);
      check("overflow clear", 32'h5a, d);
      pulse(3'h0, 1'b1, 1'b1);
      rd(OFF_PERIOD_HIGH, d, r);
      check("overflow same edge", 32'hda, d);
      $display("test overflow done");
      phs <= 10'h1ff;
      per <= 15'h7fff;
      @(posedge clk);
      rd(OFF_PHASE_HIGH, d, r);
      check("live phase high", 32'h01, d);
      rd(OFF_PHASE_LOW, d, r);
      check("live phase low", 32'hff, d);
      rd(OFF_PERIOD_LOW, d, r);
      check("live period low", 32'hff, d);
      $display("test live values done");
      summarize();
   end

   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      summarize();
   end
endmodule : test_angular_timer_period_phase_ie

`default_nettype wire
